// *** hdl/sensor_config_defs.svh ***
// Register offsets, field positions, reset values and timing counts for the sensor configuration bank.
// Assumes inclusion by bare name from the design files only; holds definitions and nothing else.
//
// Behaviour
// [RULE1] Sequencer advances on a core clock equal to the input clock divided by four.
// [RULE2] Global shutter: reset all pixels together, sample all together, read rows sequentially.
// [RULE3] Non-destructive mode reads pixels repeatedly after one reset, no reset in between.
// [RULE4] Controller changes non-destructive enable only during frame overhead periods.
// [RULE5] Controller writes configuration only while frame-valid is low.
// [RULE6] Controller changes master select and granularity only while sequencer reset is low.
// [RULE7] Sequencer control at address 0 is 11 bits, resetting to 00000101001.
// [RULE8] Master bit 1 makes all timing internal; 0 takes integration from three pins.
// [RULE9] Subsampling reads one row and skips one vertically; off after reset.
// [RULE10] Two-bit granularity selects sequencer clock division by system clock range, default 10; code only outputs it, core clock stays input/4.
// [RULE11] Analog output amplifier enable: 1 on, 0 off, off after reset.
// [RULE12] Calibration every row when bit is 1 (default), once per frame when 0.
// [RULE13] Dual slope enable applies extra reset at dual slope position; else position ignored.
// [RULE14] Triple slope enable applies extra reset at triple slope position; else ignored.
// [RULE15] Horizontal reverse reads columns right to left; default left to right.
// [RULE16] Vertical reverse reads rows bottom to top; default top to bottom.
// [RULE17] Non-destructive readout bit enables repeated-read mode; resets to 0.
// [RULE18] Column start accepts 0 to 79, readout starting at pixel eight times value.
// [RULE19] Row start accepts any row 0 through 479 as first row read.
// [RULE20] Kernel count gives 4-pixel kernels per row, 1 to 160, reset 10100000.
// [RULE21] Frame transfer position in rows, 12 bits, reset 000111100001.
// [RULE22] Reset pulse length in rows, 12 bits, reset value 2.
// [RULE23] Serial word is 16 bits: 4 address, 12 data; loaded only when complete.
// [RULE24] Shifted word loads in parallel when serial enable asserts; serial clock at most 20 MHz.
// [RULE25] Frame-valid is high while a frame is read out, low in frame overhead.
// [RULE26] In slave mode controller drives three integration pins for normal, dual, triple windows.
// [RULE27] Unused upper data bits of writes to narrow registers are ignored.
`ifndef SENSOR_CONFIG_DEFS_SVH
`define SENSOR_CONFIG_DEFS_SVH

`define ADDR_SEQUENCER_CONTROL 4'h0
`define ADDR_COLUMN_START 4'h1
`define ADDR_ROW_START 4'h2
`define ADDR_KERNEL_COUNT 4'h3
`define ADDR_RESET_PULSE_LENGTH 4'h4
`define ADDR_DUAL_SLOPE_POSITION 4'h5
`define ADDR_TRIPLE_SLOPE_POSITION 4'h6
`define ADDR_FRAME_TRANSFER_POSITION 4'h7
`define ADDR_CALIBRATION_LEVEL_DAC 4'h8
`define ADDR_BLACK_LEVEL_DAC 4'h9
`define ADDR_OFFSET_LEVEL_DAC 4'hA
`define ADDR_CONVERTER_INPUT_PATH 4'hB
`define ADDR_AMPLIFIER_SETTINGS 4'hC
`define ADDR_CONVERTER_TRIM_LOW 4'hD
`define ADDR_CONVERTER_TRIM_MID 4'hE
`define ADDR_CONVERTER_TRIM_HIGH 4'hF

`define RST_SEQUENCER_CONTROL 12'h029
`define RST_COLUMN_START 12'h000
`define RST_ROW_START 12'h000
`define RST_KERNEL_COUNT 12'h0A0
`define RST_RESET_PULSE_LENGTH 12'h002
`define RST_DUAL_SLOPE_POSITION 12'h000
`define RST_TRIPLE_SLOPE_POSITION 12'h000
`define RST_FRAME_TRANSFER_POSITION 12'h1E1
`define RST_CALIBRATION_LEVEL_DAC 12'h04A
`define RST_BLACK_LEVEL_DAC 12'h06B
`define RST_OFFSET_LEVEL_DAC 12'h055
`define RST_CONVERTER_INPUT_PATH 12'h0F0
`define RST_AMPLIFIER_SETTINGS 12'hFB0
`define RST_CONVERTER_TRIM_LOW 12'hADF
`define RST_CONVERTER_TRIM_MID 12'h6DB
`define RST_CONVERTER_TRIM_HIGH 12'h0DB

// Sequencer control field positions.
`define SEQ_MASTER 0
`define SEQ_SUBSAMPLE 1
`define SEQ_GRAN_LO 2
`define SEQ_GRAN_HI 3
`define SEQ_ANALOG_OUT 4
`define SEQ_CALIB_LINE 5
`define SEQ_DUAL_SLOPE 6
`define SEQ_TRIPLE_SLOPE 7
`define SEQ_REVERSE_X 8
`define SEQ_REVERSE_Y 9
`define SEQ_NDR 10

`define COLUMN_START_MAX 12'h04F
`define ROW_LAST 12'h1DF
`define KERNEL_MIN 12'h001
`define KERNEL_MAX 12'h0A0
`define SERIAL_WORD_BITS 16
`define CORE_DIVIDE 4
`define ROW_OVERHEAD_TICKS 12'h008
`define FRAME_OVERHEAD_TICKS 12'h010

`endif

// *** hdl/sensor_config_pkg.sv ***
// Types shared by the sensor configuration bank and its sequencer.
// Assumes nothing beyond a SystemVerilog compiler.
package sensor_config_pkg;

	typedef enum logic [3:0] {
		ST_FRAME_OVERHEAD = 4'h1,
		ST_ROW_OVERHEAD = 4'h2,
		ST_KERNELS = 4'h4,
		ST_IDLE_LINE = 4'h8
	} seq_state_t;

	typedef logic [11:0] reg_word_t;

endpackage : sensor_config_pkg

// *** hdl/core_clock_divider.sv ***
// Divides the input clock by four into a core clock and a one-cycle core tick.
// Assumes a single clock domain; the tick qualifies sequencer steps.
`timescale 1ns/10ps
`include "sensor_config_defs.svh"

module core_clock_divider (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	output logic o_core_tick,
	output logic o_core_clk
);

	logic [1:0] count_reg;

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			count_reg <= 2'h0;
		end else begin
			count_reg <= count_reg + 2'h1; // see [RULE1]
		end
	end

	assign o_core_tick = (count_reg == 2'(`CORE_DIVIDE - 1));
	assign o_core_clk = count_reg[1];

endmodule : core_clock_divider

// *** hdl/serial_word_receiver.sv ***
// Three-wire serial receiver: shifts sixteen bits MSB first and offers the word when enable rises.
// Assumes the serial clock is slow enough to be sampled by the reference clock after synchronisers.
`timescale 1ns/10ps
`include "sensor_config_defs.svh"

module serial_word_receiver (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_spi_clk,
	input wire logic i_spi_enable,
	input wire logic i_spi_data,
	output logic o_word_valid,
	output logic [15:0] o_word
);

	logic [2:0] meta_reg;
	logic [2:0] sync_reg;
	logic clk_prev_reg;
	logic en_prev_reg;
	logic [15:0] shift_reg;
	logic [4:0] count_reg;
	logic clk_rise;
	logic en_rise;
	logic word_full;

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			meta_reg <= 3'h0;
			sync_reg <= 3'h0;
			clk_prev_reg <= 1'b0;
			en_prev_reg <= 1'b0;
		end else begin
			meta_reg <= {i_spi_enable, i_spi_data, i_spi_clk};
			sync_reg <= meta_reg;
			clk_prev_reg <= sync_reg[0];
			en_prev_reg <= sync_reg[2];
		end
	end

	assign clk_rise = sync_reg[0] & ~clk_prev_reg;
	assign en_rise = sync_reg[2] & ~en_prev_reg;
	assign word_full = (count_reg == 5'(`SERIAL_WORD_BITS));

	// A partial word is dropped on enable so a glitched transfer never reaches a register.
	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			shift_reg <= 16'h0000;
			count_reg <= 5'h00;
		end else if (en_rise) begin
			count_reg <= 5'h00;
		end else if (clk_rise && !sync_reg[2]) begin
			shift_reg <= {shift_reg[14:0], sync_reg[1]};
			count_reg <= word_full ? count_reg : count_reg + 5'h01;
		end
	end

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			o_word_valid <= 1'b0;
			o_word <= 16'h0000;
		end else begin
			o_word_valid <= en_rise && word_full; // see [RULE23] see [RULE24]
			o_word <= shift_reg;
		end
	end

endmodule : serial_word_receiver

// *** hdl/image_sensor_sequencer_config.sv ***
// Configuration register bank and readout sequencer of a global-shutter image sensor.
// Assumes one reference clock; serial pins, sequencer reset and integration pins are asynchronous.
`timescale 1ns/10ps
`include "sensor_config_defs.svh"

module image_sensor_sequencer_config (
	input wire logic i_ref_clk,
	input wire logic i_reset,
	input wire logic i_sequencer_reset_n,
	input wire logic i_spi_clk,
	input wire logic i_spi_enable,
	input wire logic i_spi_data,
	input wire logic [2:0] i_int_time,
	output logic [2:0] o_int_time,
	output logic [2:0] o_int_time_oe,
	output logic o_core_clk,
	output logic o_frame_valid,
	output logic o_line_valid,
	output logic [8:0] o_row_addr,
	output logic [9:0] o_column_addr,
	output logic o_pixel_reset,
	output logic o_dual_reset,
	output logic o_triple_reset,
	output logic o_sample_store,
	output logic o_calibrate,
	output logic o_analog_out_on,
	output logic [1:0] o_granularity,
	output logic [7:0] o_calibration_level,
	output logic [7:0] o_black_level,
	output logic [7:0] o_offset_level,
	output logic [11:0] o_converter_input_path,
	output logic [11:0] o_amplifier_settings,
	output logic [32:0] o_converter_trim
);

	// ---------------------------------------------------------------
	// Helpers
	// ---------------------------------------------------------------
	function automatic logic [11:0] minus_one(input logic [11:0] value);
		minus_one = (value == 12'h000) ? 12'h000 : value - 12'h001;
	endfunction : minus_one

	function automatic logic [11:0] width_mask(input logic [3:0] addr);
		case (addr)
			`ADDR_SEQUENCER_CONTROL: width_mask = 12'h7FF;
			`ADDR_COLUMN_START, `ADDR_KERNEL_COUNT: width_mask = 12'h0FF;
			`ADDR_CALIBRATION_LEVEL_DAC, `ADDR_BLACK_LEVEL_DAC, `ADDR_OFFSET_LEVEL_DAC: width_mask = 12'h0FF;
			`ADDR_ROW_START, `ADDR_CONVERTER_TRIM_HIGH: width_mask = 12'h1FF;
			default: width_mask = 12'hFFF;
		endcase
	endfunction : width_mask

	function automatic sensor_config_pkg::reg_word_t reset_value(input int idx);
		case (idx)
			0: reset_value = `RST_SEQUENCER_CONTROL;
			1: reset_value = `RST_COLUMN_START;
			2: reset_value = `RST_ROW_START;
			3: reset_value = `RST_KERNEL_COUNT;
			4: reset_value = `RST_RESET_PULSE_LENGTH;
			5: reset_value = `RST_DUAL_SLOPE_POSITION;
			6: reset_value = `RST_TRIPLE_SLOPE_POSITION;
			7: reset_value = `RST_FRAME_TRANSFER_POSITION;
			8: reset_value = `RST_CALIBRATION_LEVEL_DAC;
			9: reset_value = `RST_BLACK_LEVEL_DAC;
			10: reset_value = `RST_OFFSET_LEVEL_DAC;
			11: reset_value = `RST_CONVERTER_INPUT_PATH;
			12: reset_value = `RST_AMPLIFIER_SETTINGS;
			13: reset_value = `RST_CONVERTER_TRIM_LOW;
			14: reset_value = `RST_CONVERTER_TRIM_MID;
			default: reset_value = `RST_CONVERTER_TRIM_HIGH;
		endcase
	endfunction : reset_value

	// ---------------------------------------------------------------
	// Clocking, serial port and pin synchronisers
	// ---------------------------------------------------------------
	logic core_tick;
	logic word_valid;
	logic [15:0] word;
	logic [3:0] pin_meta_reg;
	logic [3:0] pin_sync_reg;
	logic int1_prev_reg;

	core_clock_divider u_divider (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.o_core_tick(core_tick),
		.o_core_clk(o_core_clk)
	);

	serial_word_receiver u_serial (
		.i_ref_clk(i_ref_clk),
		.i_reset(i_reset),
		.i_spi_clk(i_spi_clk),
		.i_spi_enable(i_spi_enable),
		.i_spi_data(i_spi_data),
		.o_word_valid(word_valid),
		.o_word(word)
	);

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			pin_meta_reg <= 4'h1;
			pin_sync_reg <= 4'h1;
		end else begin
			pin_meta_reg <= {i_int_time, i_sequencer_reset_n};
			pin_sync_reg <= pin_meta_reg;
		end
	end

	logic seq_run;
	logic [2:0] int_pins;
	assign seq_run = pin_sync_reg[0];
	assign int_pins = pin_sync_reg[3:1];

	// ---------------------------------------------------------------
	// Register bank
	// ---------------------------------------------------------------
	sensor_config_pkg::reg_word_t regs [16];
	logic [3:0] wr_addr;
	logic [11:0] wr_data;
	logic [11:0] wr_masked;
	logic [11:0] wr_value;
	logic [11:0] seq_value;

	assign wr_addr = word[15:12];
	assign wr_data = word[11:0];
	assign wr_masked = wr_data & width_mask(wr_addr); // see [RULE27]

	// Mode bits that retime the sequencer are only taken while it is held in reset, so a stray
	// write cannot switch clocking or pin direction in mid-frame.
	assign seq_value = seq_run ?
		{wr_masked[11:4], regs[0][`SEQ_GRAN_HI:`SEQ_GRAN_LO], wr_masked[1], regs[0][`SEQ_MASTER]} :
		wr_masked; // see [RULE6]

	always_comb begin
		case (wr_addr)
			`ADDR_SEQUENCER_CONTROL: wr_value = seq_value; // see [RULE7]
			`ADDR_COLUMN_START: wr_value = (wr_masked > `COLUMN_START_MAX) ? `COLUMN_START_MAX : wr_masked; // see [RULE18]
			`ADDR_ROW_START: wr_value = (wr_masked > `ROW_LAST) ? `ROW_LAST : wr_masked; // see [RULE19]
			`ADDR_KERNEL_COUNT: begin
				wr_value = (wr_masked < `KERNEL_MIN) ? `KERNEL_MIN :
					(wr_masked > `KERNEL_MAX) ? `KERNEL_MAX : wr_masked; // see [RULE20]
			end
			default: wr_value = wr_masked;
		endcase
	end

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			for (int i = 0; i < 16; i++) begin
				regs[i] <= reset_value(i); // see [RULE21] see [RULE22]
			end
		end else if (word_valid) begin
			regs[wr_addr] <= wr_value; // see [RULE23]
		end
	end

	logic master_mode;
	logic subsample_on;
	logic calib_line;
	logic dual_slope_on;
	logic triple_slope_on;
	logic reverse_x;
	logic reverse_y;
	logic ndr_on;
	assign master_mode = regs[0][`SEQ_MASTER];
	assign subsample_on = regs[0][`SEQ_SUBSAMPLE];
	assign calib_line = regs[0][`SEQ_CALIB_LINE];
	assign dual_slope_on = regs[0][`SEQ_DUAL_SLOPE];
	assign triple_slope_on = regs[0][`SEQ_TRIPLE_SLOPE];
	assign reverse_x = regs[0][`SEQ_REVERSE_X];
	assign reverse_y = regs[0][`SEQ_REVERSE_Y];
	assign ndr_on = regs[0][`SEQ_NDR];

	assign o_granularity = regs[0][`SEQ_GRAN_HI:`SEQ_GRAN_LO]; // see [RULE10]
	assign o_analog_out_on = regs[0][`SEQ_ANALOG_OUT]; // see [RULE11]
	assign o_calibration_level = regs[8][7:0];
	assign o_black_level = regs[9][7:0];
	assign o_offset_level = regs[10][7:0];
	assign o_converter_input_path = regs[11];
	assign o_amplifier_settings = regs[12];
	assign o_converter_trim = {regs[15][8:0], regs[14], regs[13]};

	// ---------------------------------------------------------------
	// Readout sequencer
	// ---------------------------------------------------------------
	sensor_config_pkg::seq_state_t state_reg;
	logic [11:0] tick_count_reg;
	logic [11:0] frame_line_reg;
	logic [7:0] kernel_left_reg;
	logic ndr_reset_done_reg;
	logic row_step_done;
	logic [8:0] row_step;
	logic [8:0] row_next;
	logic [9:0] col_first;
	logic frame_transfer;
	logic int1_fall;

	assign row_step = subsample_on ? 9'h002 : 9'h001; // see [RULE9]
	assign row_next = reverse_y ? o_row_addr - row_step : o_row_addr + row_step; // see [RULE16]
	assign row_step_done = reverse_y ? (o_row_addr < row_step) :
		({3'h0, o_row_addr} + {3'h0, row_step} > `ROW_LAST);
	assign col_first = reverse_x ?
		10'({regs[1][6:0], 3'h0} + {regs[3][7:0], 2'h0} - 12'h004) :
		10'({regs[1][6:0], 3'h0}); // see [RULE15] see [RULE18]
	assign int1_fall = int1_prev_reg & ~int_pins[0];
	// In slave mode the controller's integration pin ends the frame instead of the timer.
	assign frame_transfer = master_mode ?
		(core_tick && state_reg != sensor_config_pkg::ST_FRAME_OVERHEAD &&
			frame_line_reg >= minus_one(regs[7])) :
		(int1_fall && state_reg != sensor_config_pkg::ST_FRAME_OVERHEAD); // see [RULE8] see [RULE26]

	always_ff @(posedge i_ref_clk or posedge i_reset) begin
		if (i_reset) begin
			state_reg <= sensor_config_pkg::ST_FRAME_OVERHEAD;
			tick_count_reg <= 12'h000;
			frame_line_reg <= 12'h000;
			kernel_left_reg <= 8'h00;
			o_row_addr <= 9'h000;
			o_column_addr <= 10'h000;
			ndr_reset_done_reg <= 1'b0;
			int1_prev_reg <= 1'b0;
		end else if (!seq_run) begin
			state_reg <= sensor_config_pkg::ST_FRAME_OVERHEAD;
			tick_count_reg <= 12'h000;
			frame_line_reg <= 12'h000;
			ndr_reset_done_reg <= 1'b0;
			int1_prev_reg <= int_pins[0];
		end else begin
			int1_prev_reg <= int_pins[0];
			if (!ndr_on) begin
				ndr_reset_done_reg <= 1'b0;
			end else if (o_pixel_reset) begin
				ndr_reset_done_reg <= 1'b1; // see [RULE3]
			end
			if (frame_transfer) begin
				state_reg <= sensor_config_pkg::ST_FRAME_OVERHEAD; // see [RULE2]
				tick_count_reg <= 12'h000;
			end else if (core_tick) begin // see [RULE1]
				tick_count_reg <= tick_count_reg + 12'h001;
				case (state_reg)
					sensor_config_pkg::ST_FRAME_OVERHEAD: begin
						if (tick_count_reg == `FRAME_OVERHEAD_TICKS - 12'h001) begin
							state_reg <= sensor_config_pkg::ST_ROW_OVERHEAD;
							tick_count_reg <= 12'h000;
							frame_line_reg <= 12'h000;
							o_row_addr <= regs[2][8:0]; // see [RULE19]
						end
					end
					sensor_config_pkg::ST_ROW_OVERHEAD: begin
						if (tick_count_reg == `ROW_OVERHEAD_TICKS - 12'h001) begin
							state_reg <= sensor_config_pkg::ST_KERNELS;
							kernel_left_reg <= regs[3][7:0]; // see [RULE20]
							o_column_addr <= col_first;
						end
					end
					sensor_config_pkg::ST_KERNELS: begin
						kernel_left_reg <= kernel_left_reg - 8'h01;
						o_column_addr <= (kernel_left_reg == 8'h01) ? o_column_addr :
							reverse_x ? o_column_addr - 10'h004 : o_column_addr + 10'h004;
						if (kernel_left_reg == 8'h01) begin
							tick_count_reg <= 12'h000;
							frame_line_reg <= frame_line_reg + 12'h001;
							state_reg <= row_step_done ? sensor_config_pkg::ST_IDLE_LINE :
								sensor_config_pkg::ST_ROW_OVERHEAD;
							o_row_addr <= row_step_done ? o_row_addr : row_next;
						end
					end
					sensor_config_pkg::ST_IDLE_LINE: begin
						// Keeps line timing running so integration positions still count in rows.
						if (tick_count_reg == `ROW_OVERHEAD_TICKS + {4'h0, regs[3][7:0]} - 12'h001) begin
							tick_count_reg <= 12'h000;
							frame_line_reg <= frame_line_reg + 12'h001;
						end
					end
					default: state_reg <= sensor_config_pkg::ST_FRAME_OVERHEAD;
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Frame, line and integration outputs
	// ---------------------------------------------------------------
	logic in_lines;
	logic reset_window;
	logic dual_point;
	logic triple_point;
	assign in_lines = seq_run && state_reg != sensor_config_pkg::ST_FRAME_OVERHEAD;
	assign reset_window = in_lines && frame_line_reg < minus_one(regs[4]); // see [RULE22]
	assign dual_point = in_lines && frame_line_reg == minus_one(regs[5]);
	assign triple_point = in_lines && frame_line_reg == minus_one(regs[6]);

	assign o_frame_valid = seq_run && (state_reg == sensor_config_pkg::ST_ROW_OVERHEAD ||
		state_reg == sensor_config_pkg::ST_KERNELS); // see [RULE25]
	assign o_line_valid = seq_run && state_reg == sensor_config_pkg::ST_KERNELS;
	assign o_sample_store = frame_transfer; // see [RULE2]
	assign o_calibrate = core_tick && state_reg == sensor_config_pkg::ST_ROW_OVERHEAD &&
		tick_count_reg == 12'h000 && (calib_line || frame_line_reg == 12'h000); // see [RULE12]
	assign o_pixel_reset = (master_mode ? reset_window : (seq_run && !int_pins[0])) &&
		!(ndr_on && ndr_reset_done_reg); // see [RULE2] see [RULE3] see [RULE17]
	assign o_dual_reset = dual_slope_on && (master_mode ? dual_point : (seq_run && !int_pins[1])); // see [RULE13]
	assign o_triple_reset = triple_slope_on &&
		(master_mode ? triple_point : (seq_run && !int_pins[2])); // see [RULE14]
	assign o_int_time_oe = {3{master_mode}}; // see [RULE8]
	assign o_int_time = master_mode ?
		{triple_slope_on && in_lines && frame_line_reg >= minus_one(regs[6]),
			dual_slope_on && in_lines && frame_line_reg >= minus_one(regs[5]),
			in_lines && !reset_window} : 3'h0;

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_reset);

	sequence s_word_taken;
		word_valid ##1 1'b1;
	endsequence

	a_core_tick_rate: assert property (core_tick |=> !core_tick [*3] ##1 core_tick) // see [RULE1]
		else $error("Core tick is not one in four reference clocks.");
	a_seq_width: assert property (regs[0][11] == 1'b0) // see [RULE7]
		else $error("Sequencer control holds a bit above eleven.");
	a_narrow_write: assert property (s_word_taken |-> (regs[$past(wr_addr)] & ~width_mask($past(wr_addr))) == 12'h000) // see [RULE27]
		else $error("Unused upper bits stored in a narrow register.");
	a_mode_guarded: assert property (seq_run && word_valid && wr_addr == `ADDR_SEQUENCER_CONTROL
		|=> $stable(regs[0][3:0] & 4'hD)) // see [RULE6]
		else $error("Master or granularity changed while the sequencer runs.");
	a_frame_valid_fot: assert property (state_reg == sensor_config_pkg::ST_FRAME_OVERHEAD |-> !o_frame_valid) // see [RULE25]
		else $error("Frame valid high during frame overhead.");
	a_dual_ignored: assert property (!dual_slope_on |-> !o_dual_reset && !(master_mode && o_int_time[1])) // see [RULE13]
		else $error("Dual slope reset issued while disabled.");
	a_triple_ignored: assert property (!triple_slope_on |-> !o_triple_reset) // see [RULE14]
		else $error("Triple slope reset issued while disabled.");
	a_slave_pins: assert property (!master_mode |-> o_int_time_oe == 3'h0 && o_int_time == 3'h0) // see [RULE8]
		else $error("Integration pins driven in slave mode.");
	a_column_range: assert property (o_column_addr <= 10'h27F) // see [RULE18]
		else $error("Column address beyond the array.");
	a_row_range: assert property (o_row_addr <= 9'h1DF) // see [RULE19]
		else $error("Row address beyond the array.");
	a_ndr_single: assert property (ndr_on && ndr_reset_done_reg && $stable(ndr_on) |-> !o_pixel_reset) // see [RULE3]
		else $error("Pixel reset repeated in non-destructive mode.");

endmodule : image_sensor_sequencer_config

// *** tb/config_controller_model.sv ***
// Camera controller model that drives the three-wire configuration port.
// Assumes one word at a time, paced by the bench reference clock.
`timescale 1ns/10ps

module config_controller_model (
	input wire logic i_ref_clk,
	output logic o_spi_clk,
	output logic o_spi_enable,
	output logic o_spi_data
);
	initial begin
		o_spi_clk = 1'b0;
		o_spi_enable = 1'b0;
		o_spi_data = 1'b0;
	end

	// ------------------------------------------------------------
	// Word transfer
	// ------------------------------------------------------------
	// Clock phases and the enable pulse last at least four reference cycles, so the port's synchronisers always see them.
	task automatic send(input logic [15:0] word, input int nbits);
		for (int i = 15; i > 15 - nbits; i--) begin
			@(negedge i_ref_clk) o_spi_data = word[i];
			repeat (4) @(negedge i_ref_clk);
			o_spi_clk = 1'b1;
			repeat (4) @(negedge i_ref_clk);
			o_spi_clk = 1'b0;
		end
		// The data line is not held after the word, so show the inverse level.
		o_spi_data = ~o_spi_data;
		repeat (2) @(negedge i_ref_clk);
		o_spi_enable = 1'b1;
		repeat (4) @(negedge i_ref_clk);
		o_spi_enable = 1'b0;
	endtask : send
endmodule : config_controller_model

// *** tb/image_sensor_sequencer_config_tb_top.sv ***
// Self-checking bench for the sensor configuration bank against a register model.
// Assumes the controller model file is compiled first.
`timescale 1ns/10ps

module image_sensor_sequencer_config_tb_top;
	logic i_ref_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_sequencer_reset_n = 1'b0;
	logic [2:0] i_int_time = 3'h0;
	logic spi_clk, spi_enable, spi_data, o_core_clk, o_frame_valid, o_line_valid, o_analog_out_on;
	logic [2:0] o_int_time_oe;
	logic [8:0] o_row_addr;
	logic [9:0] o_column_addr;
	logic o_pixel_reset, o_sample_store;
	logic [1:0] o_granularity;
	logic [7:0] o_calibration_level, o_black_level, o_offset_level;
	logic [11:0] o_converter_input_path, o_amplifier_settings;
	logic [32:0] o_converter_trim;
	int exp_reg[16] = '{12'h029, 12'h000, 12'h000, 12'h0A0, 12'h002, 12'h000, 12'h000, 12'h1E1,
		12'h04A, 12'h06B, 12'h055, 12'h0F0, 12'hFB0, 12'hADF, 12'h6DB, 12'h0DB};
	int wbits[16] = '{11, 8, 9, 8, 12, 12, 12, 12, 8, 8, 8, 12, 12, 12, 12, 9};
	int miscompares = 0;
	int compares = 0;
	int cycles = 0;
	int core_edges = 0;
	int n, t0;

	always #50 i_ref_clk = ~i_ref_clk;
	always @(posedge o_core_clk) core_edges++;

	config_controller_model ctl (.i_ref_clk(i_ref_clk), .o_spi_clk(spi_clk), .o_spi_enable(spi_enable),
		.o_spi_data(spi_data));

	image_sensor_sequencer_config i_dut (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
		.i_sequencer_reset_n(i_sequencer_reset_n), .i_spi_clk(spi_clk), .i_spi_enable(spi_enable),
		.i_spi_data(spi_data), .i_int_time(i_int_time), .o_int_time(), .o_int_time_oe(o_int_time_oe),
		.o_core_clk(o_core_clk), .o_frame_valid(o_frame_valid), .o_line_valid(o_line_valid),
		.o_row_addr(o_row_addr), .o_column_addr(o_column_addr), .o_pixel_reset(o_pixel_reset), .o_dual_reset(),
		.o_triple_reset(), .o_sample_store(o_sample_store), .o_calibrate(), .o_analog_out_on(o_analog_out_on),
		.o_granularity(o_granularity),
		.o_calibration_level(o_calibration_level), .o_black_level(o_black_level),
		.o_offset_level(o_offset_level), .o_converter_input_path(o_converter_input_path),
		.o_amplifier_settings(o_amplifier_settings), .o_converter_trim(o_converter_trim));

	// ------------------------------------------------------------
	// Checking and register model
	// ------------------------------------------------------------
	task automatic check(input logic [63:0] seen, input logic [63:0] want);
		compares++;
		if (seen !== want) begin
			miscompares++;
			$display("wrong value at %0t: seen %0h expected %0h", $time, seen, want);
		end
	endtask : check

	task automatic check_all;
		check(o_granularity, exp_reg[0][3:2]);
		check(o_analog_out_on, exp_reg[0][4]);
		check(o_int_time_oe, {3{exp_reg[0][0]}});
		check({o_calibration_level, o_black_level, o_offset_level}, {exp_reg[8][7:0], exp_reg[9][7:0], exp_reg[10][7:0]});
		check({o_converter_input_path, o_amplifier_settings}, {exp_reg[11][11:0], exp_reg[12][11:0]});
		check(o_converter_trim, {exp_reg[15][8:0], exp_reg[14][11:0], exp_reg[13][11:0]});
	endtask : check_all

	// While the sequencer runs, master and granularity bits keep their old values.
	task automatic wr(input logic [3:0] a, input logic [11:0] v);
		ctl.send({a, v}, 16);
		if (a == 4'h0 && i_sequencer_reset_n) v = (v & 12'hFF2) | 12'(exp_reg[0] & 12'h00D);
		v = v & 12'((1 << wbits[a]) - 1);
		if (a == 4'h3) v = (v == 12'h000) ? 12'h001 : ((v > 12'h0A0) ? 12'h0A0 : v);
		exp_reg[a] = v;
		repeat (8) @(negedge i_ref_clk);
		check_all();
	endtask : wr

	task automatic conclude;
		$display("comparisons %0d mismatches %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : conclude

	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 40000) begin
			miscompares++;
			conclude();
		end
	end

	initial begin
		void'($urandom(39537));
		repeat (8) @(negedge i_ref_clk);
		i_reset = 1'b0;
		i_int_time = 3'($urandom);
		repeat (2) @(negedge i_ref_clk);
		check({o_analog_out_on, o_granularity, o_int_time_oe[0]}, 4'h5);
		check_all();
		n = core_edges;
		repeat (40) @(negedge i_ref_clk);
		check(core_edges - n, 10);
		$display("reset and core clock test done");
		for (int a = 8; a < 16; a++) wr(a[3:0], 12'($urandom));
		for (int g = 0; g < 4; g++) wr(4'h0, 12'h021 | 12'(g << 2));
		wr(4'h0, 12'h038);
		ctl.send({4'h8, 12'h5A5}, 12);
		repeat (8) @(negedge i_ref_clk);
		check_all();
		$display("register write test done");
		wr(4'h0, 12'h029);
		wr(4'h3, 12'h000);
		wr(4'h1, 12'h017);
		wr(4'h2, 12'h1DF);
		i_sequencer_reset_n = 1'b1;
		n = 0;
		while (o_line_valid !== 1'b1 && n < 600) begin
			@(negedge i_ref_clk);
			n++;
		end
		check(o_frame_valid, 1'b1);
		// The window opens at pixel 8 x 23 of the last row, inside the first line's reset pulse.
		check({o_row_addr, o_column_addr, o_pixel_reset}, {9'h1DF, 10'h0B8, 1'b1});
		n = 0;
		while (o_line_valid === 1'b1 && n < 100) begin
			@(negedge i_ref_clk);
			n++;
		end
		check(n, 4);
		check(o_frame_valid, 1'b0);
		t0 = cycles;
		wr(4'h0, 12'h012);
		n = 0;
		while (o_sample_store !== 1'b1 && n < 20000) begin
			@(negedge i_ref_clk);
			n++;
		end
		// Transfer comes 479 idle lines of nine core ticks after the single row read.
		check((cycles - t0) / 36, 479);
		i_sequencer_reset_n = 1'b0;
		repeat (6) @(negedge i_ref_clk);
		check({o_frame_valid, o_line_valid}, 2'h0);
		$display("sequencer test done");
		conclude();
	end
endmodule : image_sensor_sequencer_config_tb_top
